// ---- verilog/sbs_defs.svh ----
// Constants of the synchronous burst SRAM port.
// Assumes inclusion by bare name from design files.
`ifndef SBS_DEFS_SVH
`define SBS_DEFS_SVH
`define SBS_ADDR_W   16
`define SBS_LANE_W   9
`define SBS_WORD_W   18
`define SBS_DEPTH    65536
`define SBS_LANE_A_LSB 0
`define SBS_LANE_B_LSB 9
`endif

// ---- verilog/sbs_pkg.sv ----
// Types of the synchronous burst SRAM port.
// Assumes sbs_defs.svh is on the include path.
`include "sbs_defs.svh"
package sbs_pkg;
    typedef logic [`SBS_ADDR_W-1:0] sbs_addr_t;
    typedef logic [`SBS_WORD_W-1:0] sbs_word_t;
    typedef enum logic [1:0] {
        SBS_IDLE,
        SBS_READ,
        SBS_WRITE
    } sbs_cycle_e;
endpackage : sbs_pkg

// ---- verilog/sbs_array.sv ----
// Storage array with per-lane write and registered read data.
// Assumes one clock; read address is presented one cycle ahead.
`timescale 1ns/1ps
`default_nettype none
module sbs_array #(
    parameter int ADDR_W = 16,
    parameter int LANE_W = 9
) (
    // Clock
    input  wire logic                clk_sys_in,
    // Write side
    input  wire logic [ADDR_W-1:0]   wr_addr_in,
    input  wire logic [2*LANE_W-1:0] wr_data_in,
    input  wire logic [1:0]          wr_lane_in,
    // Read side
    input  wire logic [ADDR_W-1:0]   rd_addr_in,
    output logic      [2*LANE_W-1:0] rd_data_out
);
    logic [2*LANE_W-1:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge clk_sys_in) begin
        if (wr_lane_in[0]) begin
            mem[wr_addr_in][LANE_W-1:0] <= wr_data_in[LANE_W-1:0];
        end
        if (wr_lane_in[1]) begin
            mem[wr_addr_in][2*LANE_W-1:LANE_W] <= wr_data_in[2*LANE_W-1:LANE_W];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        rd_data_out <= mem[rd_addr_in];
    end
endmodule : sbs_array
`default_nettype wire

// ---- verilog/sbs_port.sv ----
// Synchronous flow-through burst SRAM port, 64K x 18, two byte lanes.
// Assumes inputs synchronous to clk_sys_in; data pins resolved outside.
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defs.svh"
// Function
// - 64K words of 18 bits, two lanes
// - Two-bit internal burst address counter
// - Register address, data, controls each edge
// - Either strobe loads external address, starts burst
// - Step low advances burst counter once
// - Order select unregistered; low linear, high interleaved
// - Linear order counts up modulo four
// - Interleaved order XORs start with count
// - Writes self-timed from clock edge
// - Qualifier with lane inputs writes those lanes
// - Global write writes both lanes
// - Read data flows through, no output stage
// - Output enable asynchronous, low drives pins in read cycles only
// - Controller strobe starts read or deselect; writes in its cycle hit the old burst address, none from idle
// - Primary negated blocks processor strobe
// - Primary chip enable active low
// - Second chip enable active high
// - Third chip enable active low
module sbs_port
    import sbs_pkg::*;
#(
    parameter int ADDR_W = `SBS_ADDR_W,
    parameter int LANE_W = `SBS_LANE_W
) (
    // Clock and reset
    input  wire logic                clk_sys_in,
    input  wire logic                rst_n_in,
    // Address and strobes
    input  wire logic [ADDR_W-1:0]   addr_in,
    input  wire logic                ctrl_addr_strobe_n_in,
    input  wire logic                proc_addr_strobe_n_in,
    input  wire logic                burst_step_n_in,
    input  wire logic                burst_order_sel_n_in,
    // Chip enables
    input  wire logic                chip_sel_primary_n_in,
    input  wire logic                chip_sel_expand_hi_in,
    input  wire logic                chip_sel_expand_lo_n_in,
    // Write controls
    input  wire logic                lane_a_write_n_in,
    input  wire logic                lane_b_write_n_in,
    input  wire logic                all_lane_write_n_in,
    input  wire logic                lane_write_qual_n_in,
    input  wire logic                out_enable_n_in,
    // Data pins: input, output, enable
    input  wire logic [2*LANE_W-1:0] lane_data_in,
    output logic      [2*LANE_W-1:0] lane_data_out,
    output logic      [1:0]          lane_data_oe_out
);
    // Input registers
    logic [ADDR_W-1:0]   addr_r;
    logic [2*LANE_W-1:0] din_r;
    logic                cstb_r, pstb_r, step_r;
    logic                ce1_r, ce2_r, ce3_r;
    logic                wa_r, wb_r, wg_r, wq_r;
    logic                seen_r;
    // Burst state
    logic [ADDR_W-1:0]   base_r;
    logic [1:0]          cnt_r;
    logic                chip_sel;
    logic [ADDR_W-1:0]   cur_addr;
    logic [1:0]          lanes;
    logic                start, dsel;
    logic [2*LANE_W-1:0] rd_data;
    sbs_cycle_e          cyc_r;

    function automatic logic [1:0] burst_low(input logic [1:0] st,
                                             input logic [1:0] cnt,
                                             input logic       ilv);
        burst_low = ilv ? (st ^ cnt) : 2'(st + cnt);
    endfunction : burst_low

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            cstb_r <= 1'b1;
            pstb_r <= 1'b1;
            step_r <= 1'b1;
            ce1_r  <= 1'b1;
            ce2_r  <= 1'b0;
            ce3_r  <= 1'b1;
            wa_r   <= 1'b1;
            wb_r   <= 1'b1;
            wg_r   <= 1'b1;
            wq_r   <= 1'b1;
            seen_r <= 1'b0;
            addr_r <= '0;
            din_r  <= '0;
        end else begin
            cstb_r <= ctrl_addr_strobe_n_in;
            pstb_r <= proc_addr_strobe_n_in;
            step_r <= burst_step_n_in;
            ce1_r  <= chip_sel_primary_n_in;
            ce2_r  <= chip_sel_expand_hi_in;
            ce3_r  <= chip_sel_expand_lo_n_in;
            wa_r   <= lane_a_write_n_in;
            wb_r   <= lane_b_write_n_in;
            wg_r   <= all_lane_write_n_in;
            wq_r   <= lane_write_qual_n_in;
            addr_r <= addr_in;
            din_r  <= lane_data_in;
            seen_r <= 1'b1;
        end
    end

    // Processor strobe counts only while primary enable is low
    assign start = seen_r && (!cstb_r || (!pstb_r && !ce1_r));
    assign chip_sel = !ce1_r && ce2_r && !ce3_r;
    assign dsel  = start && !chip_sel;

    // Processor strobe cycles always read first; writes need the next
    always_comb begin
        lanes = 2'b00;
        if (!wg_r) begin
            lanes = 2'b11;
        end else if (!wq_r) begin
            lanes = {!wb_r, !wa_r};
        end
        if (start && !pstb_r && !ce1_r) begin
            lanes = 2'b00;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            base_r <= '0;
            cnt_r  <= 2'b00;
        end else if (start && !dsel) begin
            base_r <= addr_r;
            cnt_r  <= 2'b00;
        end else if (cyc_r != SBS_IDLE && !start && !step_r) begin
            cnt_r  <= 2'(cnt_r + 2'b01);
        end
    end

    // Order select is live, not registered
    assign cur_addr = {base_r[ADDR_W-1:2],
                       burst_low(base_r[1:0], cnt_r,
                                 burst_order_sel_n_in)};

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            cyc_r <= SBS_IDLE;
        end else if (dsel) begin
            cyc_r <= SBS_IDLE;
        end else if (start) begin
            cyc_r <= SBS_READ;
        end else if (cyc_r != SBS_IDLE) begin
            cyc_r <= (lanes != 2'b00) ? SBS_WRITE : SBS_READ;
        end
    end

    // Write lands at the edge after the cycle begins; no pulse needed
    sbs_array #(
        .ADDR_W (ADDR_W),
        .LANE_W (LANE_W)
    ) u_array (
        .clk_sys_in  (clk_sys_in),
        .wr_addr_in  (cur_addr),
        .wr_data_in  (din_r),
        .wr_lane_in  ((cyc_r != SBS_IDLE && !dsel) ? lanes : 2'b00),
        .rd_addr_in  (start ? addr_r : cur_addr),
        .rd_data_out (rd_data)
    );

    // Read word shown as soon as the array delivers it
    assign lane_data_out = rd_data;
    assign lane_data_oe_out = (cyc_r == SBS_READ && !out_enable_n_in)
                              ? 2'b11 : 2'b00;

    chk_oe_async: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        out_enable_n_in |-> lane_data_oe_out == 2'b00)
        else $error("Pins driven with enable high");
    chk_deselect_idle: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        dsel |=> cyc_r == SBS_IDLE)
        else $error("Deselect did not idle");
    chk_proc_blocked: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (cstb_r && ce1_r) |-> !start)
        else $error("Processor strobe not blocked");
    chk_burst_load: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (start && !dsel) |=> (base_r == $past(addr_r) && cnt_r == 2'b00))
        else $error("Burst start did not load address");
    chk_burst_step: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (cyc_r != SBS_IDLE && !start && !step_r) |=>
        cnt_r == 2'($past(cnt_r) + 2'b01))
        else $error("Burst counter did not step");
    chk_upper_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !start |=> $stable(base_r))
        else $error("Upper address changed in burst");
    chk_global_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (!wg_r && !start) |-> lanes == 2'b11)
        else $error("Global write missed a lane");
    chk_lane_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (wg_r && !wq_r && !start) |-> lanes == {!wb_r, !wa_r})
        else $error("Lane write mismatch");
    chk_enable_sel: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (start && (ce1_r || !ce2_r || ce3_r)) |=> cyc_r == SBS_IDLE)
        else $error("Chip enables ignored");
    cov_read: cover property (@(posedge clk_sys_in) cyc_r == SBS_READ);
    cov_write: cover property (@(posedge clk_sys_in) cyc_r == SBS_WRITE);
    cov_wrap: cover property (@(posedge clk_sys_in) cnt_r == 2'b11 ##1 cnt_r == 2'b00);
    cov_dsel: cover property (@(posedge clk_sys_in) dsel);
    cov_proc_start: cover property (@(posedge clk_sys_in) start && !pstb_r);
    chk_no_write_ctl: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (wg_r && wq_r) |-> lanes == 2'b00)
        else $error("Lane written without write control");
    chk_oe_read: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (cyc_r == SBS_READ && !out_enable_n_in) |-> lane_data_oe_out == 2'b11)
        else $error("Read data not driven");
    chk_order_linear: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !burst_order_sel_n_in |-> cur_addr[1:0] == 2'(base_r[1:0] + cnt_r))
        else $error("Linear order wrong");
    chk_order_ilv: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        burst_order_sel_n_in |-> cur_addr[1:0] == (base_r[1:0] ^ cnt_r))
        else $error("Interleaved order wrong");
    chk_step_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (cyc_r != SBS_IDLE && !start && step_r) |=> $stable(cnt_r))
        else $error("Counter moved while suspended");
endmodule : sbs_port
`default_nettype wire

// ---- verif/sbs_ctrl_model.sv ----
// Controller side of the shared data pins of the burst SRAM port.
// Assumes per-lane device enables; an undriven lane shows the inverse
// of its last value, so stale data never passes for fresh.
`timescale 1ns/1ps
`default_nettype none
module sbs_ctrl_model (
    // Clock
    input  wire logic        clk_sys_in,
    // Controller drive
    input  wire logic [17:0] ctl_data_in,
    input  wire logic        ctl_drive_in,
    // Device drive
    input  wire logic [17:0] dev_data_in,
    input  wire logic [1:0]  dev_oe_in,
    // Resolved pins
    output logic      [17:0] bus_data_out
);
    logic [17:0] last_r = 18'h00000;
    always_comb begin
        bus_data_out = ~last_r;
        if (ctl_drive_in) bus_data_out = ctl_data_in;
        if (dev_oe_in[0]) bus_data_out[8:0] = dev_data_in[8:0];
        if (dev_oe_in[1]) bus_data_out[17:9] = dev_data_in[17:9];
    end
    always_ff @(posedge clk_sys_in) last_r <= bus_data_out;
endmodule : sbs_ctrl_model
`default_nettype wire

// ---- verif/test_sync_burst_sram_port.sv ----
// Self-checking bench for the burst SRAM port.
// Assumes one 25 MHz clock; writes need oe held off by the controller.
`timescale 1ns/1ps
`default_nettype none
module test_sync_burst_sram_port;
    import sbs_pkg::*;
    logic        clk = 0, rst_n = 0, drv = 0;
    logic        cs_n = 1, ps_n = 1, step_n = 1, ord_n = 0;
    logic        pri_n = 0, ehi = 1, elo_n = 0, oe_n = 1;
    logic        wa_n = 1, wb_n = 1, all_n = 1, qual_n = 1;
    logic [15:0] addr = 16'h0000;
    logic [17:0] cdat = 18'h00000, dout, bus;
    logic [1:0]  oe;
    int          fail_count = 0, tests_run = 0;
    always #20 clk = ~clk;
    sbs_port uut (.clk_sys_in(clk), .rst_n_in(rst_n), .addr_in(addr),
        .ctrl_addr_strobe_n_in(cs_n), .proc_addr_strobe_n_in(ps_n),
        .burst_step_n_in(step_n), .burst_order_sel_n_in(ord_n),
        .chip_sel_primary_n_in(pri_n), .chip_sel_expand_hi_in(ehi),
        .chip_sel_expand_lo_n_in(elo_n), .lane_a_write_n_in(wa_n),
        .lane_b_write_n_in(wb_n), .all_lane_write_n_in(all_n),
        .lane_write_qual_n_in(qual_n), .out_enable_n_in(oe_n),
        .lane_data_in(bus), .lane_data_out(dout),
        .lane_data_oe_out(oe));
    sbs_ctrl_model far (.clk_sys_in(clk), .ctl_data_in(cdat),
        .ctl_drive_in(drv), .dev_data_in(dout), .dev_oe_in(oe),
        .bus_data_out(bus));
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [17:0] g, input logic [17:0] e);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check
    task automatic go(input bit p, input logic [15:0] a);
        @(posedge clk);
        if (p) ps_n <= 0;
        else cs_n <= 0;
        addr <= a;
        @(posedge clk);
        ps_n <= 1;
        cs_n <= 1;
    endtask : go
    // Suspend cycle first, so the write lands at the loaded address
    task automatic wr(input logic [15:0] a, input logic [17:0] d,
                      input logic [3:0] c, input int n);
        oe_n <= 1;
        go(0, a);
        @(posedge clk);
        for (int k = 0; k < n; k++) begin
            {all_n, qual_n, wa_n, wb_n} <= c;
            step_n <= (n == 1);
            cdat <= d + 18'(k);
            drv <= 1;
            @(posedge clk);
        end
        {all_n, qual_n, wa_n, wb_n} <= 4'hF;
        step_n <= 1;
        drv <= 0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input bit p, input logic [15:0] a,
                      input logic [17:0] e);
        oe_n <= 0;
        go(p, a);
        @(posedge clk);
        #1;
        check(bus, e);
        check(18'(oe), 18'h00003);
        @(posedge clk);
        oe_n <= 1;
        #1;
        check(18'(oe), 18'h00000);
    endtask : rd
    task automatic t_desel;
        logic [2:0] bad [3];
        bad = '{3'b110, 3'b000, 3'b011};
        for (int i = 0; i < 3; i++) begin
            go(0, 16'h1236);
            @(posedge clk);
            {pri_n, ehi, elo_n} <= bad[i];
            cs_n <= 0;
            oe_n <= 0;
            @(posedge clk);
            cs_n <= 1;
            {pri_n, ehi, elo_n} <= 3'b010;
            @(posedge clk);
            #1;
            check(18'(oe), 18'h00000);
        end
        oe_n <= 1;
        $display("deselect test done");
    endtask : t_desel
    task automatic t_ignore;
        @(posedge clk);
        oe_n <= 0;
        go(0, 16'h1236);
        @(posedge clk);
        ps_n <= 0;
        pri_n <= 1;
        addr <= 16'h2344;
        @(posedge clk);
        ps_n <= 1;
        pri_n <= 0;
        repeat (2) @(posedge clk);
        #1;
        check(bus, 18'h10001);
        check(18'(oe), 18'h00003);
        oe_n <= 1;
        $display("ignored strobe test done");
    endtask : t_ignore
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1;
        wr(16'h1235, 18'h10000, 4'h8, 4);
        rd(0, 16'h1235, 18'h10000);
        rd(0, 16'h1236, 18'h10001);
        rd(0, 16'h1237, 18'h10002);
        rd(0, 16'h1234, 18'h10003);
        $display("linear burst test done");
        ord_n <= 1;
        wr(16'h2346, 18'h20000, 4'h8, 4);
        ord_n <= 0;
        rd(1, 16'h2346, 18'h20000);
        rd(1, 16'h2347, 18'h20001);
        rd(1, 16'h2344, 18'h20002);
        rd(1, 16'h2345, 18'h20003);
        $display("interleaved burst test done");
        wr(16'h3000, 18'h3FFFF, 4'h7, 1);
        rd(0, 16'h3000, 18'h3FFFF);
        wr(16'h3000, 18'h00000, 4'hA, 1);
        rd(0, 16'h3000, 18'h001FF);
        wr(16'h3000, 18'h00000, 4'hB, 1);
        rd(0, 16'h3000, 18'h001FF);
        wr(16'h3000, 18'h155AA, 4'h8, 1);
        rd(0, 16'h3000, 18'h155AA);
        wr(16'h3000, 18'h00000, 4'h5, 1);
        rd(0, 16'h3000, 18'h00000);
        wr(16'h3000, 18'h2AAAA, 4'h9, 1);
        rd(0, 16'h3000, 18'h000AA);
        $display("lane write test done");
        t_desel();
        t_ignore();
        print_verdict();
    end
    initial begin
        #100000;
        fail_count++;
        print_verdict();
    end
endmodule : test_sync_burst_sram_port
`default_nettype wire
